// >>> common/isoc_pkg.sv
// Constants for the upstream isochrony window control block.
package isoc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_ISOC_CTRL = 8'h04;
    localparam logic [7:0] OFS_WIN0_CTRL = 8'h08;
    localparam logic [7:0] OFS_WIN0_BASE = 8'h0c;
    localparam logic [7:0] OFS_WIN0_LIMIT = 8'h10;
    localparam logic [7:0] OFS_WIN1_CTRL = 8'h14;
    localparam logic [7:0] OFS_WIN1_BASE = 8'h18;
    localparam logic [7:0] OFS_WIN1_LIMIT = 8'h1c;
    // Distance between the register groups of neighbouring windows.
    localparam logic [7:0] WIN_STRIDE = 8'h0c;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BASE_OFS = 8'h04;
    localparam logic [7:0] LIMIT_OFS = 8'h08;

    // Isochrony control fields.
    localparam int ISOC_EN_BIT = 0;
    localparam int TABLE_ARB_BIT = 1;
    localparam int AGGR_ARB_BIT = 2;
    // Window control fields.
    localparam int WIN_EN_BIT = 0;
    localparam int TC_LSB = 1;
    localparam int TC_MSB = 3;

    // Window counts: this block owns the first two of the four.
    localparam int NUM_WINDOWS = 2;
    localparam logic [3:0] TOTAL_WINDOWS = 4'h4;

    // Widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TC_W = 3;
    localparam int MASTERS = 4;

    // Values after reset.
    localparam logic RST_BIT = 1'h0;
    localparam logic [TC_W-1:0] TC0 = 3'h0;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [MASTERS-1:0] RST_GNT = 4'h0;
endpackage

// >>> src/isoc_window_ctrl.sv
// Behaviour
// - Control register bits 15:3 read zero and ignore writes.
// - Aggressive bit writable only with table arbitration on, else 0.
// - Aggressive mode stops masters mid-transaction to protect isochrony.
// - Table enable 0 leaves the arbiter to the classic control registers.
// - Table enable 1 lets the arbitration table decide grants exclusively.
// - Global isochrony off maps all upstream traffic to class zero.
// - Window control bits 15:4 read zero.
// - Window control bits 3:1 hold the traffic class, reset 000b.
// - A disabled window never affects upstream classification.
// - An enabled window tags in-range upstream traffic with its class; where both windows hit, window 0's class wins.
// - Window base is full 32-bit read/write, scratch when disabled.
// - Window 0 at 08h, 0Ch, 10h; window 1 at 14h, 18h.
// - Window limit is 32-bit read/write upper bound, reset zero.
// - Isochrony control at 04h resets to zero, all features off.
// - Window 1 limit at 1Ch, 32-bit read/write, reset zero.
// - Four windows exist in the bridge; this block owns windows 0 and 1.
//
// Implementation choice: the address-and-strobe port.
module isoc_window_ctrl (
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    // Register port.
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Upstream transaction classification.
    input wire logic UP_VALID_I,
    input wire logic [31:0] UP_ADDR_I,
    output logic UP_TC_VALID_O,
    output logic [2:0] UP_TC_O,
    output logic UP_HIT_O,
    // Secondary bus arbiter steering.
    input wire logic [3:0] CLASSIC_GNT_I,
    input wire logic [3:0] TABLE_GNT_I,
    input wire logic ISOC_PENDING_I,
    input wire logic BUS_BUSY_I,
    output logic [3:0] GNT_O,
    output logic STOP_MASTER_O,
    output logic TABLE_MODE_O
);
    localparam int NW = isoc_pkg::NUM_WINDOWS;

    // True when the address selects the given register of window w.
    function automatic logic win_sel(input logic [7:0] a, input int w,
                                     input logic [7:0] ofs);
        logic [7:0] target;
        target = isoc_pkg::OFS_WIN0_CTRL + ofs
                 + 8'(w) * isoc_pkg::WIN_STRIDE;
        win_sel = (a == target);
    endfunction

    logic global_isochrony_enable;
    logic vc_table_arb_enable;
    logic aggressive_arb_enable;
    logic window_match_enable [NW];
    logic [2:0] window_traffic_class [NW];
    logic [31:0] window_base [NW];
    logic [31:0] window_limit [NW];
    logic [NW-1:0] hit;
    logic [2:0] next_tc;
    logic next_hit;
    logic [31:0] next_rdata;
    logic ctrl_wr;

    assign ctrl_wr = WR_I && (ADDR_I == isoc_pkg::OFS_ISOC_CTRL);

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            global_isochrony_enable <= isoc_pkg::RST_BIT;
            vc_table_arb_enable <= isoc_pkg::RST_BIT;
        end else if (ctrl_wr) begin
            global_isochrony_enable <= WDATA_I[isoc_pkg::ISOC_EN_BIT];
            vc_table_arb_enable <= WDATA_I[isoc_pkg::TABLE_ARB_BIT];
        end
    end

    // gated aggressive bit
    // The bit follows the table enable written in the same access and
    // is forced clear whenever the table enable is cleared.
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aggressive_arb_enable <= isoc_pkg::RST_BIT;
        end else if (ctrl_wr) begin
            aggressive_arb_enable <= WDATA_I[isoc_pkg::AGGR_ARB_BIT]
                                     && WDATA_I[isoc_pkg::TABLE_ARB_BIT];
        end
    end

    genvar gw;
    generate
        for (gw = 0; gw < NW; gw++) begin : g_win
            always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    window_match_enable[gw] <= isoc_pkg::RST_BIT;
                    window_traffic_class[gw] <= isoc_pkg::TC0;
                end else if (WR_I && win_sel(ADDR_I, gw,
                                             isoc_pkg::CTRL_OFS)) begin
                    window_match_enable[gw] <=
                        WDATA_I[isoc_pkg::WIN_EN_BIT];
                    window_traffic_class[gw] <=
                        WDATA_I[isoc_pkg::TC_MSB:isoc_pkg::TC_LSB];
                end
            end

            always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    window_base[gw] <= isoc_pkg::RST_WORD;
                end else if (WR_I && win_sel(ADDR_I, gw,
                                             isoc_pkg::BASE_OFS)) begin
                    window_base[gw] <= WDATA_I;
                end
            end

            always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    window_limit[gw] <= isoc_pkg::RST_WORD;
                end else if (WR_I && win_sel(ADDR_I, gw,
                                             isoc_pkg::LIMIT_OFS)) begin
                    window_limit[gw] <= WDATA_I;
                end
            end

            window_match u_match (
                .base_i(window_base[gw]),
                .limit_i(window_limit[gw]),
                .enable_i(window_match_enable[gw]
                          && global_isochrony_enable),
                .addr_i(UP_ADDR_I),
                .hit_o(hit[gw])
            );
        end
    endgenerate

    always_comb begin
        next_tc = isoc_pkg::TC0;
        next_hit = 1'b0;
        for (int w = NW - 1; w >= 0; w--) begin
            if (hit[w]) begin
                next_tc = window_traffic_class[w];
                next_hit = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            UP_TC_VALID_O <= 1'b0;
            UP_TC_O <= isoc_pkg::TC0;
            UP_HIT_O <= 1'b0;
        end else begin
            UP_TC_VALID_O <= UP_VALID_I;
            UP_TC_O <= UP_VALID_I ? next_tc : isoc_pkg::TC0;
            UP_HIT_O <= UP_VALID_I && next_hit;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            GNT_O <= isoc_pkg::RST_GNT;
        end else begin
            GNT_O <= vc_table_arb_enable ? TABLE_GNT_I : CLASSIC_GNT_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            STOP_MASTER_O <= 1'b0;
        end else begin
            STOP_MASTER_O <= aggressive_arb_enable && vc_table_arb_enable
                             && ISOC_PENDING_I && BUS_BUSY_I;
        end
    end

    assign TABLE_MODE_O = vc_table_arb_enable;

    // reserved zero
    // Unmapped addresses read zero.
    always_comb begin
        next_rdata = isoc_pkg::RST_WORD;
        if (ADDR_I == isoc_pkg::OFS_ISOC_CTRL) begin
            next_rdata[isoc_pkg::ISOC_EN_BIT] = global_isochrony_enable;
            next_rdata[isoc_pkg::TABLE_ARB_BIT] = vc_table_arb_enable;
            next_rdata[isoc_pkg::AGGR_ARB_BIT] = aggressive_arb_enable
                                                 && vc_table_arb_enable;
        end
        for (int w = 0; w < NW; w++) begin
            if (win_sel(ADDR_I, w, isoc_pkg::CTRL_OFS)) begin
                next_rdata[isoc_pkg::WIN_EN_BIT] = window_match_enable[w];
                next_rdata[isoc_pkg::TC_MSB:isoc_pkg::TC_LSB] =
                    window_traffic_class[w];
            end
            if (win_sel(ADDR_I, w, isoc_pkg::BASE_OFS)) begin
                next_rdata = window_base[w];
            end
            if (win_sel(ADDR_I, w, isoc_pkg::LIMIT_OFS)) begin
                next_rdata = window_limit[w];
            end
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= isoc_pkg::RST_WORD;
        end else begin
            RDATA_O <= RD_I ? next_rdata : isoc_pkg::RST_WORD;
        end
    end

    property p_ctrl_rsvd;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        RD_I && ADDR_I == isoc_pkg::OFS_ISOC_CTRL |=> RDATA_O[31:3] == '0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("Reserved control bits read nonzero.");

    property p_aggr_gate;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        ctrl_wr && !WDATA_I[1] ##1 RD_I && ADDR_I == isoc_pkg::OFS_ISOC_CTRL
        |=> RDATA_O[2] == 1'b0;
    endproperty
    a_aggr_gate: assert property (p_aggr_gate)
        else $error("Aggressive bit set without table enable.");

    property p_stop;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        aggressive_arb_enable && ISOC_PENDING_I && BUS_BUSY_I
        |=> STOP_MASTER_O;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Busy master not stopped in aggressive mode.");

    property p_classic;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        !vc_table_arb_enable |=> GNT_O == $past(CLASSIC_GNT_I)
                                 && !STOP_MASTER_O;
    endproperty
    a_classic: assert property (p_classic)
        else $error("Grant not from classic arbiter.");

    property p_table;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        vc_table_arb_enable |=> GNT_O == $past(TABLE_GNT_I);
    endproperty
    a_table: assert property (p_table)
        else $error("Grant not from arbitration table.");

    property p_tc0_global;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        UP_VALID_I && !global_isochrony_enable
        |=> UP_TC_VALID_O && UP_TC_O == isoc_pkg::TC0 && !UP_HIT_O;
    endproperty
    a_tc0_global: assert property (p_tc0_global)
        else $error("Nonzero class with isochrony disabled.");

    property p_win_rsvd;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        RD_I && (ADDR_I == isoc_pkg::OFS_WIN0_CTRL
                 || ADDR_I == isoc_pkg::OFS_WIN1_CTRL)
        |=> RDATA_O[31:4] == '0;
    endproperty
    a_win_rsvd: assert property (p_win_rsvd)
        else $error("Reserved window control bits read nonzero.");

    property p_win0_hit;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        UP_VALID_I && global_isochrony_enable && window_match_enable[0]
        && UP_ADDR_I >= window_base[0] && UP_ADDR_I <= window_limit[0]
        |=> UP_HIT_O && UP_TC_O == $past(window_traffic_class[0]);
    endproperty
    a_win0_hit: assert property (p_win0_hit)
        else $error("Window 0 hit not tagged with its class.");

    property p_nohit;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        UP_VALID_I && !window_match_enable[0] && !window_match_enable[1]
        |=> UP_TC_O == isoc_pkg::TC0 && !UP_HIT_O;
    endproperty
    a_nohit: assert property (p_nohit)
        else $error("Disabled windows changed the class.");

    property p_base_rw;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        WR_I && ADDR_I == isoc_pkg::OFS_WIN1_BASE
        ##1 RD_I && ADDR_I == isoc_pkg::OFS_WIN1_BASE
        |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    a_base_rw: assert property (p_base_rw)
        else $error("Base register did not read back.");
endmodule

// >>> src/window_match.sv
// Address range compare for one upstream isochronous window.
module window_match (
    // Window programming.
    input wire logic [31:0] base_i,
    input wire logic [31:0] limit_i,
    input wire logic enable_i,
    // Address under test.
    input wire logic [31:0] addr_i,
    // Result.
    output logic hit_o
);
    // The range is inclusive at both ends; an inverted range never hits.
    assign hit_o = enable_i && (addr_i >= base_i) && (addr_i <= limit_i);
endmodule

// >>> test/tb_upstream_isochrony_window_control.sv
// Self-checking testbench for the upstream isochrony window control block.
module tb_upstream_isochrony_window_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic up_valid = 1'b0;
    logic [31:0] up_addr = 32'h0000_0000;
    logic up_tc_valid;
    logic [2:0] up_tc;
    logic up_hit;
    logic [3:0] classic_gnt = 4'h5;
    logic [3:0] table_gnt = 4'ha;
    logic isoc_pending = 1'b0;
    logic bus_busy = 1'b0;
    logic [3:0] gnt;
    logic stop_master;
    logic table_mode;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] ofs_list [7];

    isoc_window_ctrl u_dut (
        .MCLK_I(mclk), .RESET_N_I(reset_n),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata),
        .UP_VALID_I(up_valid), .UP_ADDR_I(up_addr),
        .UP_TC_VALID_O(up_tc_valid), .UP_TC_O(up_tc), .UP_HIT_O(up_hit),
        .CLASSIC_GNT_I(classic_gnt), .TABLE_GNT_I(table_gnt),
        .ISOC_PENDING_I(isoc_pending), .BUS_BUSY_I(bus_busy),
        .GNT_O(gnt), .STOP_MASTER_O(stop_master), .TABLE_MODE_O(table_mode)
    );

    always #2.5 mclk = ~mclk;

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp,
                          input string nm);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
        @(posedge mclk);
        #1;
        chk("rdata idle", 32'h0, rdata);
    endtask

    // Write followed by a read of the same address with no gap.
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [31:0] exp, input string nm);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask

    task automatic probe(input logic [31:0] a, input logic [2:0] tc,
                         input logic hit);
        @(posedge mclk);
        up_valid <= 1'b1;
        up_addr <= a;
        @(posedge mclk);
        up_valid <= 1'b0;
        #1;
        chk("up_tc_valid", 32'h1, {31'h0, up_tc_valid});
        chk("up_tc", {29'h0, tc}, {29'h0, up_tc});
        chk("up_hit", {31'h0, hit}, {31'h0, up_hit});
        @(posedge mclk);
        #1;
        chk("up_tc_valid idle", 32'h0, {31'h0, up_tc_valid});
        chk("up_tc idle", 32'h0, {29'h0, up_tc});
    endtask

    task automatic arb(input logic pend, input logic busy,
                       input logic [3:0] exp_gnt, input logic exp_stop);
        @(posedge mclk);
        isoc_pending <= pend;
        bus_busy <= busy;
        @(posedge mclk);
        #1;
        chk("gnt", {28'h0, exp_gnt}, {28'h0, gnt});
        chk("stop_master", {31'h0, exp_stop}, {31'h0, stop_master});
    endtask

    task automatic print_verdict;
        $display("Checks made %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(5ns * 4000);
        mismatches++;
        $display("FAIL watchdog expected done seen hang");
        print_verdict();
    end

    initial begin
        ofs_list = '{isoc_pkg::OFS_ISOC_CTRL, isoc_pkg::OFS_WIN0_CTRL,
                     isoc_pkg::OFS_WIN0_BASE, isoc_pkg::OFS_WIN0_LIMIT,
                     isoc_pkg::OFS_WIN1_CTRL, isoc_pkg::OFS_WIN1_BASE,
                     isoc_pkg::OFS_WIN1_LIMIT};
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (ofs_list[i]) begin
            rd_reg(ofs_list[i], 32'h0, "reset");
        end
        rd_reg(8'h00, 32'h0, "unmapped 00");
        chk("table_mode", 32'h0, {31'h0, table_mode});
        $display("Test reset values done");

        wr_reg(isoc_pkg::OFS_ISOC_CTRL, 32'hffff_fffd);
        rd_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h1, "ctrl no table");
        wr_rd(isoc_pkg::OFS_ISOC_CTRL, 32'h5, 32'h1, "ctrl b2b");
        wr_reg(isoc_pkg::OFS_ISOC_CTRL, 32'hffff_ffff);
        rd_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h7, "ctrl all set");
        chk("table_mode", 32'h1, {31'h0, table_mode});
        wr_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h0000_0004);
        rd_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h0, "ctrl aggr alone");
        foreach (ofs_list[i]) begin
            if (i > 0) begin
                wr_reg(ofs_list[i], 32'ha5c3_5a3c);
            end
        end
        rd_reg(isoc_pkg::OFS_WIN0_CTRL, 32'hc, "win0 ctrl");
        rd_reg(isoc_pkg::OFS_WIN0_BASE, 32'ha5c3_5a3c, "win0 base");
        rd_reg(isoc_pkg::OFS_WIN0_LIMIT, 32'ha5c3_5a3c, "win0 lim");
        rd_reg(isoc_pkg::OFS_WIN1_CTRL, 32'hc, "win1 ctrl");
        rd_reg(isoc_pkg::OFS_WIN1_BASE, 32'ha5c3_5a3c, "win1 base");
        wr_rd(isoc_pkg::OFS_WIN1_BASE, 32'h5a3c_a5c3, 32'h5a3c_a5c3,
              "win1 base b2b");
        rd_reg(isoc_pkg::OFS_WIN1_LIMIT, 32'ha5c3_5a3c, "win1 lim");
        wr_reg(8'h20, 32'hffff_ffff);
        rd_reg(8'h20, 32'h0, "unmapped 20");
        $display("Test register access done");

        wr_reg(isoc_pkg::OFS_WIN0_BASE, 32'h0000_1000);
        wr_reg(isoc_pkg::OFS_WIN0_LIMIT, 32'h0000_1fff);
        wr_reg(isoc_pkg::OFS_WIN0_CTRL, 32'h0000_000b);
        wr_reg(isoc_pkg::OFS_WIN1_BASE, 32'h0000_1800);
        wr_reg(isoc_pkg::OFS_WIN1_LIMIT, 32'h0000_2fff);
        wr_reg(isoc_pkg::OFS_WIN1_CTRL, 32'h0000_0007);
        probe(32'h0000_1000, 3'h0, 1'b0);
        wr_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h0000_0001);
        probe(32'h0000_0fff, 3'h0, 1'b0);
        probe(32'h0000_1000, 3'h5, 1'b1);
        probe(32'h0000_1fff, 3'h5, 1'b1);
        probe(32'h0000_2000, 3'h3, 1'b1);
        probe(32'h0000_2fff, 3'h3, 1'b1);
        probe(32'h0000_3000, 3'h0, 1'b0);
        wr_reg(isoc_pkg::OFS_WIN0_CTRL, 32'h0000_000a);
        probe(32'h0000_1800, 3'h3, 1'b1);
        probe(32'h0000_1000, 3'h0, 1'b0);
        wr_reg(isoc_pkg::OFS_WIN1_CTRL, 32'h0000_0006);
        probe(32'h0000_1800, 3'h0, 1'b0);
        $display("Test classification done");

        arb(1'b1, 1'b1, 4'h5, 1'b0);
        wr_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h0000_0002);
        arb(1'b1, 1'b1, 4'ha, 1'b0);
        wr_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h0000_0006);
        arb(1'b1, 1'b1, 4'ha, 1'b1);
        arb(1'b0, 1'b1, 4'ha, 1'b0);
        arb(1'b1, 1'b0, 4'ha, 1'b0);
        $display("Test arbiter steering done");

        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk("gnt after reset", 32'h0, {28'h0, gnt});
        chk("table_mode after reset", 32'h0, {31'h0, table_mode});
        rd_reg(isoc_pkg::OFS_ISOC_CTRL, 32'h0, "ctrl after reset");
        rd_reg(isoc_pkg::OFS_WIN0_LIMIT, 32'h0, "lim after reset");
        $display("Test mid-run reset done");
        print_verdict();
    end
endmodule
